// ### include/spcfg_map.svh
// register offsets, field positions, reset values for the serial port config bank
// assumes an 8-bit register address and 8-bit data from the two-wire port logic
`ifndef SPCFG_MAP_SVH
`define SPCFG_MAP_SVH
`define SPCFG_ADDR_PORT_CFG    8'h00
`define SPCFG_ADDR_DIE_REV     8'h02
`define SPCFG_ADDR_VARIANT     8'h03
`define SPCFG_ADDR_RB_SEL      8'h04
`define SPCFG_ADDR_TAG_LOW     8'h05
`define SPCFG_ADDR_TAG_HIGH    8'h06
`define SPCFG_BIT_SOFT_RESET   5
`define SPCFG_BIT_RB_ACTIVE    0
`define SPCFG_RST_PORT_CFG     8'h00
`define SPCFG_RST_RB_SEL       8'h00
`define SPCFG_RST_TAG          8'h00
`endif

// ### include/spcfg_pkg.sv
// types for the serial port config bank
// assumes nothing beyond the map header
package spcfg_pkg;
    typedef enum logic [2:0] {
        SPCFG_IDLE   = 3'b001,
        SPCFG_ARMED  = 3'b010,
        SPCFG_WAIT   = 3'b100
    } spcfg_sr_state_t;
endpackage

// ### src/spcfg_regs.sv
// serial port configuration and identification registers, two-wire mode
// assumes the two-wire slave logic on clk_sys presents decoded register
// writes, reads and an end-of-write-transaction pulse; scl comes from the pin
`timescale 1ns/1ns
`include "spcfg_map.svh"
module spcfg_regs #(
    parameter logic [7:0] DIE_REVISION = 8'h01, // arbitrary value
    parameter logic [7:0] VARIANT_CODE = 8'h5a  // arbitrary value
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       scl_pin,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_done,
    input  wire logic       rd_en,
    input  wire logic [7:0] rd_addr,
    input  wire logic [7:0] active_rd_data,
    output logic      [7:0] rd_data,
    output logic            readback_active,
    output logic            soft_reset
);
    localparam logic [7:0] CFG_RESET = `SPCFG_RST_PORT_CFG;
    localparam logic [7:0] SEL_RESET = `SPCFG_RST_RB_SEL;
    localparam logic [7:0] TAG_RESET = `SPCFG_RST_TAG;

    logic [2:0]                 scl_sync;
    logic                       scl_rise;
    logic                       wr_cfg;
    logic                       wr_sel;
    logic                       wr_tag_low;
    logic                       wr_tag_high;
    logic                       sr_request;
    logic                       sr_clear;
    logic                       defaults_load;
    logic                       soft_reset_bit;
    logic [7:0]                 rb_sel;
    logic [7:0]                 tag_low;
    logic [7:0]                 tag_high;
    spcfg_pkg::spcfg_sr_state_t sr_state;
    logic [7:0]                 buf_data;
    logic                       use_active;

    // a decoded write that lands on one register
    function automatic logic wr_hits(
        input logic       en,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        wr_hits = en && (addr == target);
    endfunction

    // register zero image: low nibble is the high nibble in reversed bit order
    function automatic logic [7:0] cfg_image(
        input logic [3:0] upper
    );
        cfg_image = {upper, upper[0], upper[1], upper[2], upper[3]};
    endfunction

    // two-flop sync, third stage keeps the last level for the edge
    // reset to the released high level so no false rise follows reset
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            scl_sync <= 3'h7;
        end
        else
        begin
            scl_sync <= {scl_sync[1:0], scl_pin};
        end
    end

    assign scl_rise    = scl_sync[1] & ~scl_sync[2];
    assign wr_cfg      = wr_hits(wr_en, wr_addr, `SPCFG_ADDR_PORT_CFG);
    assign wr_sel      = wr_hits(wr_en, wr_addr, `SPCFG_ADDR_RB_SEL);
    assign wr_tag_low  = wr_hits(wr_en, wr_addr, `SPCFG_ADDR_TAG_LOW);
    assign wr_tag_high = wr_hits(wr_en, wr_addr, `SPCFG_ADDR_TAG_HIGH);
    // revision and variant addresses get no write strobe at all

    // only bit 5 is looked at; 7:6, 4 and the bit 6 order select have no storage
    assign sr_request    = wr_cfg && wr_data[`SPCFG_BIT_SOFT_RESET];
    assign sr_clear      = (sr_state == spcfg_pkg::SPCFG_WAIT) && scl_rise;
    assign defaults_load = !rst_b || soft_reset_bit;

    // arming waits for the stop so the clear cannot hit the same transaction
    // a transaction cut before its stop keeps the bank in soft reset until one
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sr_state <= spcfg_pkg::SPCFG_IDLE;
        end
        else
        begin
            unique case (sr_state)
                spcfg_pkg::SPCFG_IDLE:
                begin
                    if (sr_request)
                        sr_state <= spcfg_pkg::SPCFG_ARMED;
                end
                spcfg_pkg::SPCFG_ARMED:
                begin
                    if (wr_done)
                        sr_state <= spcfg_pkg::SPCFG_WAIT;
                end
                spcfg_pkg::SPCFG_WAIT:
                begin
                    // a fresh request wins over the clearing edge
                    if (sr_request)
                        sr_state <= spcfg_pkg::SPCFG_ARMED;
                    else if (scl_rise)
                        sr_state <= spcfg_pkg::SPCFG_IDLE;
                end
                default:
                    sr_state <= spcfg_pkg::SPCFG_IDLE;
            endcase
        end
    end

    // set wins over the clear when both land in one cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            soft_reset_bit <= CFG_RESET[`SPCFG_BIT_SOFT_RESET];
        end
        else if (sr_request)
        begin
            soft_reset_bit <= 1'b1;
        end
        else if (sr_clear || sr_state == spcfg_pkg::SPCFG_IDLE)
        begin
            soft_reset_bit <= 1'b0;
        end
    end

    // soft reset holds the writable registers at defaults while it stands
    always_ff @(posedge clk_sys)
    begin
        if (defaults_load)
        begin
            rb_sel <= SEL_RESET;
        end
        else if (wr_sel)
        begin
            rb_sel <= {7'h00, wr_data[`SPCFG_BIT_RB_ACTIVE]};
        end
    end

    // the two tag bytes are independent; no staging between them
    always_ff @(posedge clk_sys)
    begin
        if (defaults_load)
        begin
            tag_low <= TAG_RESET;
        end
        else if (wr_tag_low)
        begin
            tag_low <= wr_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (defaults_load)
        begin
            tag_high <= TAG_RESET;
        end
        else if (wr_tag_high)
        begin
            tag_high <= wr_data;
        end
    end

    // tag bytes feed only this mux, nothing else reads them
    always_comb
    begin
        unique case (rd_addr)
            `SPCFG_ADDR_PORT_CFG:
                buf_data = cfg_image({2'b00, soft_reset_bit, 1'b0});
            `SPCFG_ADDR_DIE_REV:  buf_data = DIE_REVISION;
            `SPCFG_ADDR_VARIANT:  buf_data = VARIANT_CODE;
            `SPCFG_ADDR_RB_SEL:   buf_data = rb_sel;
            `SPCFG_ADDR_TAG_LOW:  buf_data = tag_low;
            `SPCFG_ADDR_TAG_HIGH: buf_data = tag_high;
            default:              buf_data = 8'h00;
        endcase
    end

    // ids and the select itself always read from here; higher addresses may not
    assign use_active = rb_sel[`SPCFG_BIT_RB_ACTIVE]
                        && (rd_addr > `SPCFG_ADDR_TAG_HIGH);

    // registered answer, held until the next read request
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            rd_data <= 8'h00;
        end
        else if (rd_en && use_active)
        begin
            rd_data <= active_rd_data;
        end
        else if (rd_en)
        begin
            rd_data <= buf_data;
        end
    end

    assign readback_active = rb_sel[`SPCFG_BIT_RB_ACTIVE];
    assign soft_reset      = soft_reset_bit;
endmodule // spcfg_regs

// ### bench/spcfg_host.sv
// host stand-in: register cycles, stop pulse, scl activity
// assumes decoded one-cycle strobes on clk_sys; scl idles high like a pulled-up line
`timescale 1ns/1ns
module spcfg_host (
    input  wire logic       clk_sys,
    output logic            scl_pin,
    output logic            wr_en,
    output logic            wr_done,
    output logic            rd_en,
    output logic      [7:0] wr_addr,
    output logic      [7:0] wr_data,
    output logic      [7:0] rd_addr,
    output logic      [7:0] active_rd_data
);
    initial
    begin
        {wr_en, wr_done, rd_en, wr_addr, wr_data, rd_addr} = '0;
        scl_pin = 1'b1;
    end
    assign active_rd_data = 8'hc5;
    // every write is a single-byte transaction closed by a stop
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_sys) {wr_en, wr_addr, wr_data} <= {1'b1, a, d};
        @(posedge clk_sys) {wr_en, wr_done} <= 2'b01;
        @(posedge clk_sys) wr_done <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys) {rd_en, rd_addr} <= {1'b1, a};
        @(posedge clk_sys) rd_en <= 1'b0;
    endtask
    // scl stands high outside frames: one low phase, one rise per call,
    // then enough edges for the synchroniser and the clear to settle
    task automatic scl_clk();
        @(posedge clk_sys) scl_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        scl_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
endmodule // spcfg_host

// ### bench/spcfg_checker.sv
// assertions on the config bank ports
// bound to spcfg_regs from the testbench
`timescale 1ns/1ns
module spcfg_checker #(
    parameter logic [7:0] DIE_REVISION = 8'h01,
    parameter logic [7:0] VARIANT_CODE = 8'h5a
) (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       scl_pin,
    input wire logic       wr_en,
    input wire logic       wr_done,
    input wire logic       rd_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic       readback_active,
    input wire logic       soft_reset
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence sr_armed; soft_reset && wr_done; endsequence
    sequence scl_up; $rose(scl_pin); endsequence
    sr_set_a: assert property (wr_en && wr_addr == 8'h00 && wr_data[5] |=> soft_reset)
        else $error("soft reset not raised");
    sr_dflt_a: assert property (soft_reset [*2] |-> !readback_active)
        else $error("select not at default");
    sr_keep_a: assert property ((soft_reset && !scl_pin) [*4] |=> soft_reset)
        else $error("soft reset dropped without scl");
    sr_clear_a: assert property (sr_armed ##[1:40] scl_up |-> ##[1:5] !soft_reset)
        else $error("soft reset not cleared");
    rb_sel_a: assert property (wr_en && wr_addr == 8'h04 && wr_data[0] && !soft_reset
        |=> readback_active) else $error("select not stored");
    rev_rd_a: assert property (rd_en && rd_addr == 8'h02 |=> rd_data == DIE_REVISION)
        else $error("revision wrong");
    var_rd_a: assert property (rd_en && rd_addr == 8'h03 |=> rd_data == VARIANT_CODE)
        else $error("variant wrong");
    cfg0_rd_a: assert property (rd_en && rd_addr == 8'h00 |=> !rd_data[7] && !rd_data[6]
        && !rd_data[4]) else $error("unused bits not zero");
endmodule // spcfg_checker

// ### bench/spcfg_regs_test.sv
// self-checking bench for the config bank
// assumes the host stand-in drives every bank input except clk_sys and rst_b, which this bench drives
`timescale 1ns/1ns
module spcfg_regs_test;
    logic       clk_sys = 1'b0, rst_b = 1'b0, scl_pin, wr_en, wr_done, rd_en;
    logic       readback_active, soft_reset;
    logic [7:0] wr_addr, wr_data, rd_addr, active_rd_data, rd_data;
    int         n_mismatch = 0, total_checks = 0;
    always #2 clk_sys = ~clk_sys;
    spcfg_host u_host (
        .clk_sys        (clk_sys),
        .scl_pin        (scl_pin),
        .wr_en          (wr_en),
        .wr_done        (wr_done),
        .rd_en          (rd_en),
        .wr_addr        (wr_addr),
        .wr_data        (wr_data),
        .rd_addr        (rd_addr),
        .active_rd_data (active_rd_data)
    );
    // ids arbitrary
    spcfg_regs #(
        .DIE_REVISION   (8'h3c),
        .VARIANT_CODE   (8'h9e)
    ) u_dut (
        .clk_sys         (clk_sys),
        .rst_b           (rst_b),
        .scl_pin         (scl_pin),
        .wr_en           (wr_en),
        .wr_addr         (wr_addr),
        .wr_data         (wr_data),
        .wr_done         (wr_done),
        .rd_en           (rd_en),
        .rd_addr         (rd_addr),
        .active_rd_data  (active_rd_data),
        .rd_data         (rd_data),
        .readback_active (readback_active),
        .soft_reset      (soft_reset)
    );
    task automatic chk(input string n, input logic [7:0] e, s);
        total_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, e);
        u_host.rd(a);
        #1 chk("rd_data", e, rd_data);
    endtask
    // writes to read-only places must not stick
    task automatic t_ids();
        u_host.wr(8'h02, 8'hff);
        u_host.wr(8'h03, 8'h00);
        rdchk(8'h02, 8'h3c);
        rdchk(8'h03, 8'h9e);
    endtask
    task automatic t_tags();
        rdchk(8'h05, 8'h00);
        u_host.wr(8'h05, 8'ha7);
        u_host.wr(8'h06, 8'h5c);
        rdchk(8'h05, 8'ha7);
        rdchk(8'h06, 8'h5c);
        chk("readback_active", 8'h00, {7'h00, readback_active});
    endtask
    // above the bank the select picks the host's active data
    task automatic t_rb_sel();
        rdchk(8'h10, 8'h00);
        u_host.wr(8'h04, 8'h01);
        chk("readback_active", 8'h01, {7'h00, readback_active});
        rdchk(8'h04, 8'h01);
        rdchk(8'h10, 8'hc5);
    endtask
    // unused bits set too, they must read back zero
    task automatic t_soft();
        u_host.wr(8'h00, 8'hff);
        rdchk(8'h00, 8'h24);
        rdchk(8'h04, 8'h00);
        rdchk(8'h05, 8'h00);
        chk("soft_reset", 8'h01, {7'h00, soft_reset});
        u_host.scl_clk();
        #1 chk("soft_reset", 8'h00, {7'h00, soft_reset});
        rdchk(8'h06, 8'h00);
        rdchk(8'h00, 8'h00);
        rdchk(8'h10, 8'h00);
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_ids();
        t_tags();
        t_rb_sel();
        t_soft();
        final_report();
    end
endmodule // spcfg_regs_test
bind spcfg_regs spcfg_checker #(
    .DIE_REVISION    (DIE_REVISION),
    .VARIANT_CODE    (VARIANT_CODE)
) u_chk (
    .clk_sys         (clk_sys),
    .rst_b           (rst_b),
    .scl_pin         (scl_pin),
    .wr_en           (wr_en),
    .wr_done         (wr_done),
    .rd_en           (rd_en),
    .wr_addr         (wr_addr),
    .wr_data         (wr_data),
    .rd_addr         (rd_addr),
    .rd_data         (rd_data),
    .readback_active (readback_active),
    .soft_reset      (soft_reset)
);
